// >>> uif_defs.vh
// Purpose: Constants for the USB interrupt and error flag block
// Assumes: 200 MHz hclk, AHB-Lite register access, 32-bit data
// Notes:   Register offsets are byte addresses
`ifndef UIF_DEFS_VH
`define UIF_DEFS_VH

// ============================================================
// Register map
`define UIF_OFS_IRQ_FLAGS   4'h0
`define UIF_OFS_IRQ_EN      4'h4
`define UIF_OFS_ERR_FLAGS   4'h8
`define UIF_OFS_ERR_EN      4'hC
`define UIF_OFS_CTRL        5'h10
`define UIF_OFS_EVENTS      5'h14

// ============================================================
// Interrupt flag positions
`define UIF_B_STALL   7
`define UIF_B_ATTACH  6
`define UIF_B_RESUME  5
`define UIF_B_IDLE    4
`define UIF_B_TOKEN   3
`define UIF_B_SOF     2
`define UIF_B_ERRSUM  1
`define UIF_B_RST     0

// Error flag positions
`define UIF_B_STUFF   7
`define UIF_B_ERRGAP  6
`define UIF_B_OVR     5
`define UIF_B_TURN    4
`define UIF_B_PART    3
`define UIF_B_CRC16   2
`define UIF_B_CRC5    1
`define UIF_B_PID     0

// Implemented masks and reset value
`define UIF_IRQ_W1C_MASK  8'hFD
`define UIF_ERR_MASK      8'hBF
`define UIF_ZERO8         8'h00

// ============================================================
// Timing: times in ns, counts derived at 5 ns per cycle
`define UIF_CLK_NS        5
`define UIF_T_SHORT_NS    2500
`define UIF_T_IDLE_NS     3000000
`define UIF_N_SHORT       (`UIF_T_SHORT_NS / `UIF_CLK_NS)
`define UIF_N_IDLE        (`UIF_T_IDLE_NS / `UIF_CLK_NS)
`define UIF_CNT_W         20

// AHB transfer type and size
`define UIF_HTRANS_NONSEQ 2'b10
`define UIF_HSIZE_WORD    3'b010

`endif

// >>> uif_irq_flags.v
// Purpose: USB interrupt status/enable and error status/enable registers
// Assumes: Events come from the USB engine on hclk;
//          line levels from pins are synchronised here
// Notes:   Flags are write-one-to-clear on full-word writes only
`timescale 1ns/100ps
`include "uif_defs.vh"

// Notes on behaviour
// [R1] Stall handshake sets flag bit 7
// [R2] Host: non-SE0 quiet 2.5 us sets attach
// [R3] K-state held 2.5 us sets resume
// [R4] Idle held 3 ms sets idle flag
// [R5] Token done sets flag; clear advances status
// [R6] SOF received or host threshold sets flag; only ev_sof sets it here, there is no host threshold
// [R7] Error summary read-only, ORs enabled errors
// [R8] Host detach flag rearms after reset clears
// [R9] Full-word write-one clears each flag except the bit 1 summary
// [R10] Enables mask flags; attach enable device-zero
// [R11] Enable bit 0 covers reset or detach
// [R12] Bit stuffing violation sets stuff flag
// [R13] Buffer overrun sets flag, data truncated
// [R14] Turnaround timeout sets flag
// [R15] Partial byte data field sets flag
// [R16] CRC16 failure sets flag
// [R17] Bit 1: CRC5 device, end-of-frame host
// [R18] PID check failure sets flag
// [R19] Error enables gate into summary
// [R20] Upper byte and bit 6 read zero
// [R21] Device: 2.5 us bus reset, rearm after
// [R22] One interrupt output; all resets zero
module uif_irq_flags #(
    parameter IDLE_CYCLES = `UIF_N_IDLE
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // Bus line states from pins
    input  wire        line_se0,
    input  wire        line_kstate,
    input  wire        line_idle,
    input  wire        line_activity,
    // Events from the USB engine (one-cycle pulses)
    input  wire        ev_stall_sent,
    input  wire        ev_token_done,
    input  wire        ev_sof,
    input  wire        ev_stuff_err,
    input  wire        ev_overrun,
    input  wire        ev_turn_timeout,
    input  wire        ev_partial_byte,
    input  wire        ev_crc16_err,
    input  wire        ev_crc5_err,
    input  wire        ev_eof_err,
    input  wire        ev_pid_err,
    // Outputs
    output wire        host_mode,
    output wire        token_status_advance,
    output wire        rx_truncate,
    output wire        usb_irq
);

    // ============================================================
    // Pin synchronisers
    reg [3:0] sync1_q;
    reg [3:0] sync2_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {line_activity, line_idle, line_kstate, line_se0};
            sync2_q <= sync1_q;
        end
    end
    wire se0_s  = sync2_q[0];
    wire k_s    = sync2_q[1];
    wire idle_s = sync2_q[2];
    wire act_s  = sync2_q[3];

    // ============================================================
    // AHB address phase capture
    reg        wr_q;
    reg        rd_q;
    reg [4:0]  addr_q;
    wire take = hsel && hready && (htrans == `UIF_HTRANS_NONSEQ);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            addr_q <= 5'h00;
        end else begin
            wr_q   <= take && hwrite && (hsize == `UIF_HSIZE_WORD);
            rd_q   <= take && !hwrite;
            addr_q <= haddr[4:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    wire wr_irq  = wr_q && (addr_q == {1'b0, `UIF_OFS_IRQ_FLAGS});
    wire wr_ien  = wr_q && (addr_q == {1'b0, `UIF_OFS_IRQ_EN});
    wire wr_err  = wr_q && (addr_q == {1'b0, `UIF_OFS_ERR_FLAGS});
    wire wr_een  = wr_q && (addr_q == {1'b0, `UIF_OFS_ERR_EN});
    wire wr_ctrl = wr_q && (addr_q == `UIF_OFS_CTRL);

    // ============================================================
    // Control register: bit 0 selects host mode
    reg host_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            host_q <= 1'b0; // R22
        else if (wr_ctrl)
            host_q <= hwdata[0];
    end
    assign host_mode = host_q;

    // ============================================================
    // Line-state timers
    reg [`UIF_CNT_W-1:0] quiet_cnt_q;
    reg [`UIF_CNT_W-1:0] k_cnt_q;
    reg [`UIF_CNT_W-1:0] idle_cnt_q;
    reg [`UIF_CNT_W-1:0] se0_cnt_q;
    reg                  attach_arm_q;
    reg                  resume_arm_q;
    reg                  idle_arm_q;
    reg                  rst_arm_q;
    // Counts are formed at 32 bits and cut to the counter width on purpose
    localparam [31:0]           N_SHORT_W = `UIF_N_SHORT;
    localparam [31:0]           N_IDLE_W  = IDLE_CYCLES;
    localparam [`UIF_CNT_W-1:0] N_SHORT   = N_SHORT_W[`UIF_CNT_W-1:0];
    localparam [`UIF_CNT_W-1:0] N_IDLE    = N_IDLE_W[`UIF_CNT_W-1:0];

    wire quiet_hit = (quiet_cnt_q == N_SHORT) && attach_arm_q;
    wire k_hit     = (k_cnt_q == N_SHORT) && resume_arm_q;
    wire idle_hit  = (idle_cnt_q == N_IDLE) && idle_arm_q;
    wire se0_hit   = (se0_cnt_q == N_SHORT) && rst_arm_q;

    // ============================================================
    // Attach timer: non-SE0 with no activity, host only
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet_cnt_q  <= {`UIF_CNT_W{1'b0}};
            attach_arm_q <= 1'b1;
        end else if (se0_s || act_s || !host_q) begin
            quiet_cnt_q  <= {`UIF_CNT_W{1'b0}};
            attach_arm_q <= 1'b1;
        end else if (quiet_cnt_q != N_SHORT) begin
            quiet_cnt_q <= quiet_cnt_q + 1'b1; // R2
        end else begin
            attach_arm_q <= 1'b0;
        end
    end

    // ============================================================
    // Resume timer: continuous K-state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            k_cnt_q      <= {`UIF_CNT_W{1'b0}};
            resume_arm_q <= 1'b1;
        end else if (!k_s) begin
            k_cnt_q      <= {`UIF_CNT_W{1'b0}};
            resume_arm_q <= 1'b1;
        end else if (k_cnt_q != N_SHORT) begin
            k_cnt_q <= k_cnt_q + 1'b1; // R3
        end else begin
            resume_arm_q <= 1'b0;
        end
    end

    // ============================================================
    // Idle timer: continuous idle state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_cnt_q <= {`UIF_CNT_W{1'b0}};
            idle_arm_q <= 1'b1;
        end else if (!idle_s) begin
            idle_cnt_q <= {`UIF_CNT_W{1'b0}};
            idle_arm_q <= 1'b1;
        end else if (idle_cnt_q != N_IDLE) begin
            idle_cnt_q <= idle_cnt_q + 1'b1; // R4
        end else begin
            idle_arm_q <= 1'b0;
        end
    end

    // ============================================================
    // SE0 timer: bus reset (device) or detach (host)
    // Rearms only once SE0 has ended, so a long reset flags once
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            se0_cnt_q <= {`UIF_CNT_W{1'b0}};
            rst_arm_q <= 1'b1;
        end else if (!se0_s) begin
            se0_cnt_q <= {`UIF_CNT_W{1'b0}};
            rst_arm_q <= 1'b1; // R8 R21
        end else if (se0_cnt_q != N_SHORT) begin
            se0_cnt_q <= se0_cnt_q + 1'b1;
        end else begin
            rst_arm_q <= 1'b0;
        end
    end

    // ============================================================
    // Interrupt flags and enables
    reg  [7:0] irq_q;
    reg  [7:0] ien_q;
    wire [7:0] irq_set;
    assign irq_set[`UIF_B_STALL]  = ev_stall_sent;             // R1
    assign irq_set[`UIF_B_ATTACH] = quiet_hit && host_q;       // R2
    assign irq_set[`UIF_B_RESUME] = k_hit;                     // R3
    assign irq_set[`UIF_B_IDLE]   = idle_hit;                  // R4
    assign irq_set[`UIF_B_TOKEN]  = ev_token_done;             // R5
    assign irq_set[`UIF_B_SOF]    = ev_sof;                    // R6
    assign irq_set[`UIF_B_ERRSUM] = 1'b0;
    assign irq_set[`UIF_B_RST]    = se0_hit;                   // R8 R21

    wire [7:0] irq_clr = wr_irq ? (hwdata[7:0] & `UIF_IRQ_W1C_MASK) : `UIF_ZERO8;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= `UIF_ZERO8;
            ien_q <= `UIF_ZERO8;
        end else begin
            irq_q <= (irq_q & ~irq_clr) | irq_set; // R9
            if (wr_ien)
                ien_q <= hwdata[7:0]; // R10 R11
        end
    end
    // Software popping a token entry
    assign token_status_advance = irq_clr[`UIF_B_TOKEN] && irq_q[`UIF_B_TOKEN]; // R5

    // ============================================================
    // Error flags and enables
    reg  [7:0] err_q;
    reg  [7:0] een_q;
    wire [7:0] err_set;
    assign err_set[`UIF_B_STUFF]  = ev_stuff_err;     // R12
    assign err_set[`UIF_B_ERRGAP] = 1'b0;             // R20
    assign err_set[`UIF_B_OVR]    = ev_overrun;       // R13
    assign err_set[`UIF_B_TURN]   = ev_turn_timeout;  // R14
    assign err_set[`UIF_B_PART]   = ev_partial_byte;  // R15
    assign err_set[`UIF_B_CRC16]  = ev_crc16_err;     // R16
    assign err_set[`UIF_B_CRC5]   = host_q ? ev_eof_err : ev_crc5_err; // R17
    assign err_set[`UIF_B_PID]    = ev_pid_err;       // R18

    wire [7:0] err_clr = wr_err ? (hwdata[7:0] & `UIF_ERR_MASK) : `UIF_ZERO8;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_q <= `UIF_ZERO8;
            een_q <= `UIF_ZERO8;
        end else begin
            err_q <= (err_q & ~err_clr) | err_set; // R9
            if (wr_een)
                een_q <= hwdata[7:0] & `UIF_ERR_MASK; // R20
        end
    end
    assign rx_truncate = ev_overrun; // R13

    // ============================================================
    // Summary and interrupt output
    wire       err_sum = |(err_q & een_q); // R7 R19
    wire [7:0] ien_vis = host_q ? ien_q : (ien_q & ~(8'h01 << `UIF_B_ATTACH)); // R10
    wire [7:0] irq_vis;
    assign irq_vis = {irq_q[7:2], err_sum, irq_q[0]}; // R7
    assign usb_irq = |(irq_vis & ien_vis); // R22

    // ============================================================
    // Read word selection from the address phase
    reg [31:0] rd_word_d;
    always @* begin
        rd_word_d = 32'h0000_0000;
        case (haddr[4:0])
            {1'b0, `UIF_OFS_IRQ_FLAGS}: rd_word_d = {24'h000000, irq_vis};    // R20
            {1'b0, `UIF_OFS_IRQ_EN}:    rd_word_d = {24'h000000, ien_vis};
            {1'b0, `UIF_OFS_ERR_FLAGS}: rd_word_d = {24'h000000, err_q};
            {1'b0, `UIF_OFS_ERR_EN}:    rd_word_d = {24'h000000, een_q};
            `UIF_OFS_CTRL:              rd_word_d = {31'h00000000, host_q};
            `UIF_OFS_EVENTS:            rd_word_d = {28'h0000000, act_s, idle_s, k_s, se0_s};
            default:                    rd_word_d = 32'h0000_0000;
        endcase
    end

    // Read data, driven from flip-flops; stands until the next read
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
            hrdata <= rd_word_d;
    end

endmodule

// >>> uif_bus_model.sv
// Purpose: Far-side stand-in: USB engine events and bus line levels
// Assumes: Bench requests change just after a rising hclk edge
// Notes:   Events leave as one-cycle pulses one edge after the request
`timescale 1ns/100ps
module uif_bus_model (
    // Clock
    input  wire        hclk,
    // Requests from the bench
    input  wire [10:0] ev_cmd,
    input  wire [3:0]  line_cmd,
    // Toward the block
    output reg  [10:0] ev_q,
    output reg  [3:0]  line_q
);
    initial ev_q = 11'h000;
    initial line_q = 4'h1;
    always @(posedge hclk) begin
        ev_q <= ev_cmd;
        line_q <= line_cmd;
    end
endmodule

// >>> uif_irq_checker.sv
// Purpose: Port assertions for the USB flag block
// Assumes: Zero-wait slave, word transfers
// Notes:   Interrupt enables are shadowed from bus writes
`timescale 1ns/100ps
module uif_irq_checker (
    // Bus side
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    // Engine side and outputs
    input wire        ev_stall_sent,
    input wire        ev_sof,
    input wire        ev_overrun,
    input wire        host_mode,
    input wire        token_status_advance,
    input wire        rx_truncate,
    input wire        usb_irq
);
    reg        wr_q;
    reg        rd_q;
    reg        rdh_q;
    reg  [4:0] ad_q;
    reg  [7:0] ien_q;
    wire       take = hsel && htrans == 2'h2 && hsize == 3'h2;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            rdh_q <= 1'b0;
            ad_q <= 5'h00;
            ien_q <= 8'h00;
        end else begin
            wr_q <= take && hwrite;
            rd_q <= take && !hwrite;
            rdh_q <= host_mode;
            ad_q <= haddr[4:0];
            if (wr_q && ad_q == 5'h04) begin
                ien_q <= hwdata[7:0];
            end
        end
    end
    // ============================================================
    // Properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_ev(e, en);
        e && en;
    endsequence
    a_trunc_copy: assert property (rx_truncate == ev_overrun)
        else $error("truncate does not follow overrun");
    a_quiet_reset: assert property (disable iff (1'b0)
        !hresetn |-> !usb_irq && hrdata == 32'h0 && !host_mode) else $error("active in reset");
    a_advance_cause: assert property (token_status_advance |-> wr_q && ad_q == 5'h00 && hwdata[3])
        else $error("advance without token clear");
    a_upper_zero: assert property (rd_q && !ad_q[4] |-> hrdata[31:8] == 24'h0)
        else $error("upper bits not zero");
    a_gap_zero: assert property (rd_q && ad_q[4:3] == 2'h1 |-> !hrdata[6])
        else $error("error bit six not zero");
    a_attach_dev: assert property (rd_q && ad_q == 5'h04 && !rdh_q |-> !hrdata[6])
        else $error("attach enable visible in device mode");
    a_masked_quiet: assert property (ien_q == 8'h00 |-> !usb_irq)
        else $error("interrupt with all enables off");
    a_stall_irq: assert property (s_ev(ev_stall_sent, ien_q[7]) |=> usb_irq)
        else $error("stall did not raise interrupt");
    a_sof_irq: assert property (s_ev(ev_sof, ien_q[2]) |=> usb_irq)
        else $error("frame start did not raise interrupt");
endmodule
bind uif_irq_flags uif_irq_checker uif_irq_checker_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hrdata, .ev_stall_sent, .ev_sof, .ev_overrun, .host_mode,
    .token_status_advance, .rx_truncate, .usb_irq);

// >>> uif_irq_flags_tb.sv
// Purpose: Self-checking bench for the USB flag block
// Assumes: Idle time shortened to 50 cycles
// Notes:   Event rows hold index, flag and error values
`timescale 1ns/100ps
module uif_irq_flags_tb;
    localparam logic [19:0] ROWS [11] = '{20'hA8000, 20'h90800, 20'h80400, 20'h70280,
        20'h60220, 20'h50210, 20'h40208, 20'h30204, 20'h20202, 20'h10000, 20'h00201};
    localparam logic [12:0] LROWS [5] = '{13'h0901, 13'h0420, 13'h0210, 13'h1901, 13'h1040};
    logic        hclk = 1'b0;
    logic        hresetn = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [10:0] ev_cmd = 11'h000;
    logic [3:0]  line_cmd = 4'h1;
    logic [31:0] r;
    wire  [10:0] ev;
    wire  [3:0]  ln;
    wire         hreadyout;
    wire  [31:0] hrdata;
    wire         usb_irq;
    wire         hresp_w;
    wire         host_w;
    int          bad_count = 0;
    int          comparisons = 0;
    int          i;
    always #2.5 hclk = ~hclk;
    uif_bus_model uif_bus_model_i (.hclk(hclk), .ev_cmd(ev_cmd), .line_cmd(line_cmd),
        .ev_q(ev), .line_q(ln));
    uif_irq_flags #(.IDLE_CYCLES(50)) uif_irq_flags_i (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp_w),
        .hrdata(hrdata),
        .line_se0(ln[3]), .line_kstate(ln[2]), .line_idle(ln[1]), .line_activity(ln[0]),
        .ev_stall_sent(ev[10]), .ev_token_done(ev[9]), .ev_sof(ev[8]), .ev_stuff_err(ev[7]),
        .ev_overrun(ev[6]), .ev_turn_timeout(ev[5]), .ev_partial_byte(ev[4]),
        .ev_crc16_err(ev[3]), .ev_crc5_err(ev[2]), .ev_eof_err(ev[1]), .ev_pid_err(ev[0]),
        .host_mode(host_w), .token_status_advance(), .rx_truncate(), .usb_irq(usb_irq));
    // ============================================================
    // Tasks
    task give_verdict;
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task xfer(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {27'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    task rd_chk(input logic [4:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    task pulse(input int k);
        ev_cmd <= 11'h001 << k;
        @(posedge hclk);
        ev_cmd <= 11'h000;
        repeat (3) @(posedge hclk);
    endtask
    // ============================================================
    // Sequence
    initial begin
        #100000;
        bad_count++;
        give_verdict;
    end
    initial begin
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 5; i++) rd_chk(5'(i * 4), 32'h0);
        chk({31'h0, hresp_w}, 32'h0);
        pulse(10);
        pulse(9);
        chk({31'h0, usb_irq}, 32'h0);
        rd_chk(5'h00, 32'h88);
        hsize <= 3'h1;
        xfer(1'b1, 5'h00, 32'hFFFF_FFFF, r);
        hsize <= 3'h2;
        rd_chk(5'h00, 32'h88);
        xfer(1'b1, 5'h00, 32'h80, r);
        rd_chk(5'h00, 32'h08);
        xfer(1'b1, 5'h00, 32'hFFFF_FFFF, r);
        xfer(1'b1, 5'h04, 32'hFFFF_FFFF, r);
        rd_chk(5'h04, 32'hBF);
        xfer(1'b1, 5'h0C, 32'hFFFF_FFFF, r);
        rd_chk(5'h0C, 32'hBF);
        rd_chk(5'h18, 32'h0);
        for (i = 0; i < 11; i++) begin
            pulse(ROWS[i][19:16]);
            rd_chk(5'h00, {24'h0, ROWS[i][15:8]});
            rd_chk(5'h08, {24'h0, ROWS[i][7:0]});
            chk({31'h0, usb_irq}, {31'h0, ROWS[i][15:8] != 8'h00});
            xfer(1'b1, 5'h08, 32'hFFFF_FFFF, r);
            xfer(1'b1, 5'h00, 32'hFFFF_FFFF, r);
        end
        for (i = 0; i < 5; i++) begin
            xfer(1'b1, 5'h10, {31'h0, LROWS[i][12]}, r);
            @(posedge hclk);
            chk({31'h0, host_w}, {31'h0, LROWS[i][12]});
            line_cmd <= LROWS[i][11:8];
            repeat (520) @(posedge hclk);
            rd_chk(5'h00, {24'h0, LROWS[i][7:0]});
            xfer(1'b1, 5'h00, 32'hFFFF_FFFF, r);
            repeat (520) @(posedge hclk);
            rd_chk(5'h00, 32'h0);
            line_cmd <= 4'h1;
            repeat (8) @(posedge hclk);
        end
        rd_chk(5'h04, 32'hFF);
        pulse(2);
        rd_chk(5'h08, 32'h0);
        pulse(1);
        rd_chk(5'h08, 32'h02);
        give_verdict;
    end
endmodule
